// ### core/ssr_link.sv
// Link-side shifter on the serial clock: drives return bits, takes message
// Assumes frame_tog_i and snap_i settle before the first serial clock edge
module ssr_link
  import ssr_pkg::*;
#(
  parameter int WORD_W = SSR_WORD_W
)
(
  input wire logic sclk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic frame_tog_i,
  input wire logic [WORD_W-1:0] snap_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic [WORD_W-1:0] rx_o,
  output logic [$clog2(WORD_W)-1:0] cnt_o,
  output logic multi_o,
  output logic tog_o
);

  localparam int CW = $clog2(WORD_W);

  logic tx_tog;
  logic tx_past;
  logic [CW-1:0] tx_idx;
  logic oe_clr;

  if (WORD_W < 2 || (WORD_W & (WORD_W - 1)) != 0)
  begin : g_chk
    $error("ssr_link word width must be a power of two");
  end

  // Sample on falling edge; new frame seen through the toggle
  always_ff @(negedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_o <= '0;
      cnt_o <= '0;
      multi_o <= 1'b0;
      tog_o <= 1'b0;
    end
    else if (frame_tog_i != tog_o)
    begin
      tog_o <= frame_tog_i;
      rx_o <= {{(WORD_W-1){1'b0}}, si_i};
      cnt_o <= CW'(1);
      multi_o <= 1'b0;
    end
    else
    begin
      rx_o <= {rx_o[WORD_W-2:0], si_i};
      cnt_o <= cnt_o + 1'b1;
      if (cnt_o == CW'(WORD_W - 1))
        multi_o <= 1'b1;
    end
  end

  // Drive on rising edge: snapshot MSB first, then delayed input
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      so_o <= 1'b0;
      tx_tog <= 1'b0;
      tx_idx <= '0;
      tx_past <= 1'b0;
    end
    else if (frame_tog_i != tx_tog)
    begin
      tx_tog <= frame_tog_i;
      so_o <= snap_i[WORD_W-1];
      tx_idx <= CW'(1);
      tx_past <= 1'b0;
    end
    else
    begin
      so_o <= tx_past ? rx_o[WORD_W-1] : snap_i[~tx_idx];
      tx_idx <= tx_idx + 1'b1;
      if (tx_idx == '1)
        tx_past <= 1'b1;
    end
  end

  // Pin released at once when the frame ends
  assign oe_clr = !rst_n_i || cs_n_i;

  always_ff @(posedge sclk_i or posedge oe_clr)
  begin
    if (oe_clr)
      so_oe_n_o <= 1'b1;
    else
      so_oe_n_o <= 1'b0;
  end

endmodule

// ### core/ssr_pkg.sv
// Shared constants and types for the serial status readback block
// Assumes a 16-bit serial word and four switched output channels
package ssr_pkg;

  localparam int SSR_WORD_W = 16;
  localparam int SSR_CH_N = 4;
  localparam int SSR_SYNC_RST = 0;

  // Message address field: low three bits, channel bits above them
  localparam logic [2:0] SSR_A_STAT = 3'h0;
  localparam logic [2:0] SSR_A_SOCH = 3'h2;
  localparam logic [2:0] SSR_A_CDTOL = 3'h3;
  localparam logic [2:0] SSR_A_DIC = 3'h4;
  localparam logic [4:0] SSR_A_SERIAL_OUTPUT_COMMANDS = 5'h01;
  localparam logic [4:0] SSR_A_SENSE_ENABLE_BITS = 5'h09;
  localparam logic [4:0] SSR_A_UOV = 5'h05;
  localparam logic [4:0] SSR_A_WD = 5'h0d;
  localparam logic [4:0] SSR_A_PIN0 = 5'h06;
  localparam logic [4:0] SSR_A_PIN1 = 5'h0e;
  localparam logic [4:0] SSR_A_PIN2 = 5'h0f;

  localparam logic [3:0] SSR_NIB_RST = 4'h0;
  localparam logic [4:0] SSR_SEL_RST = 5'h00;
  localparam logic [3:0] SSR_CFG_RST = 4'h0;

  typedef struct packed {
    logic ot;
    logic och;
    logic ocl;
    logic ol;
  } ssr_fault_t;

  typedef struct packed {
    logic wd;
    logic [1:0] spare;
    logic [4:0] addr;
    logic [2:0] pad;
    logic [4:0] data;
  } ssr_msg_t;

  typedef struct packed {
    logic wd;
    logic uv;
    logic ov;
    logic [4:0] sel;
    logic [3:0] st;
    logic [3:0] nib;
  } ssr_word_t;

  localparam ssr_word_t SSR_WORD_RST = '0;

endpackage

// ### core/ssr_sync.sv
// Two-stage level synchroniser for pin inputs into the system clock
// Assumes inputs are slow levels; first stage feeds only the second
module ssr_sync
  import ssr_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  if (W < 1)
  begin : g_chk
    $error("ssr_sync width must be at least one");
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= W'(SSR_SYNC_RST);
      q_o <= W'(SSR_SYNC_RST);
    end
    else if (ce_i)
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ### core/ssr_top.sv
// Serial status readback: return word, message store, fault status pin
// Assumes chip select low three system clocks before the first serial edge
module ssr_top
  import ssr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire ssr_fault_t [SSR_CH_N-1:0] FAULT_I,
  input wire logic LOW_SUPPLY_I,
  input wire logic HIGH_SUPPLY_I,
  input wire logic WD_EXPIRED_I,
  input wire logic WD_ACTIVE_I,
  input wire logic [1:0] FAILSAFE_OUT_I,
  input wire logic WAKE_I,
  input wire logic [SSR_CH_N-1:0] DIRECT_IN_I,
  output logic SO_O,
  output logic SO_OE_N_O,
  output logic FS_N_O
);

  localparam int CW = $clog2(SSR_WORD_W);

  logic [7:0] pins_s;
  logic cs_s;
  logic cs_act;
  logic cs_d;
  logic wake_s;
  logic [1:0] fsafe_s;
  logic [3:0] din_s;
  logic [3:0] din_d;
  logic frame_start;
  logic frame_end;
  logic frame_tog;
  logic accept;
  logic [SSR_WORD_W-1:0] rx_word;
  logic [CW-1:0] rx_cnt;
  logic rx_multi;
  logic rx_tog;
  ssr_msg_t msg;
  ssr_word_t word;
  ssr_word_t snap;
  logic wd_echo;
  logic seen;
  logic [4:0] sel_echo;
  logic [4:0] rd_sel;
  logic [3:0] on_cmd;
  logic [3:0] sense_en_n;
  logic [3:0] uov;
  logic [3:0] wdcfg;
  logic [3:0] soch [SSR_CH_N];
  logic [3:0] cdtol [SSR_CH_N];
  logic [3:0] dic [SSR_CH_N];
  logic [3:0] nib;
  logic [3:0] st;
  logic [3:0] flt_latch;
  logic [3:0] latch_set;
  logic [3:0] off_cmd;

  if (SSR_CH_N != 4)
  begin : g_chk
    $error("ssr_top word layout serves exactly four channels");
  end

  function automatic logic hit(input ssr_msg_t m, input logic [4:0] a);
    return m.addr == a;
  endfunction

  function automatic logic hit_ch(input ssr_msg_t m, input logic [2:0] a);
    return m.addr[2:0] == a;
  endfunction

  ssr_sync #(.W(8)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    // Select enters inverted: zero reset then reads as idle, no false frame start
    .d_i({!CS_N_I, FAILSAFE_OUT_I, WAKE_I, DIRECT_IN_I}),
    .q_o(pins_s)
  );

  assign {cs_act, fsafe_s, wake_s, din_s} = pins_s;
  // Synced select, high while idle, matches the reset value of cs_d
  assign cs_s = !cs_act;

  ssr_link #(.WORD_W(SSR_WORD_W)) u_link (
    .sclk_i(SCLK_I),
    .rst_n_i(RST_N_I),
    .cs_n_i(CS_N_I),
    .si_i(SI_I),
    .frame_tog_i(frame_tog),
    .snap_i(snap),
    .so_o(SO_O),
    .so_oe_n_o(SO_OE_N_O),
    .rx_o(rx_word),
    .cnt_o(rx_cnt),
    .multi_o(rx_multi),
    .tog_o(rx_tog)
  );

  assign frame_start = cs_d && !cs_s;
  assign frame_end = !cs_d && cs_s;
  assign msg = ssr_msg_t'(rx_word);
  // Link state is static once the serial clock has stopped
  assign accept = CE_I && frame_end && rx_multi && rx_cnt == '0 && rx_tog == frame_tog;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cs_d <= 1'b1;
      frame_tog <= 1'b0;
    end
    else if (CE_I)
    begin
      cs_d <= cs_s;
      if (frame_start)
        frame_tog <= !frame_tog;
    end
  end

  // Echo fields of the last accepted message
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wd_echo <= 1'b0;
      sel_echo <= SSR_SEL_RST;
      seen <= 1'b0;
    end
    else if (accept)
    begin
      wd_echo <= msg.wd;
      sel_echo <= msg.data;
      seen <= 1'b1;
    end
  end

  // Readback selector only moves on a status-select write
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rd_sel <= SSR_SEL_RST;
    else if (accept && hit_ch(msg, SSR_A_STAT))
      rd_sel <= msg.data;
  end

  // Configuration store; invalid frames never reach here
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      on_cmd <= SSR_CFG_RST;
      sense_en_n <= SSR_CFG_RST;
      uov <= SSR_CFG_RST;
      wdcfg <= SSR_CFG_RST;
      for (int c = 0; c < SSR_CH_N; c++)
      begin
        soch[c] <= SSR_CFG_RST;
        cdtol[c] <= SSR_CFG_RST;
        dic[c] <= SSR_CFG_RST;
      end
    end
    else if (accept)
    begin
      if (hit(msg, SSR_A_SERIAL_OUTPUT_COMMANDS))
        on_cmd <= msg.data[3:0];
      if (hit(msg, SSR_A_SENSE_ENABLE_BITS))
        sense_en_n <= msg.data[3:0];
      if (hit(msg, SSR_A_UOV))
        uov <= msg.data[3:0];
      if (hit(msg, SSR_A_WD))
        wdcfg <= msg.data[3:0];
      if (hit_ch(msg, SSR_A_SOCH))
        soch[msg.addr[4:3]] <= msg.data[3:0];
      if (hit_ch(msg, SSR_A_CDTOL))
        cdtol[msg.addr[4:3]] <= msg.data[3:0];
      if (hit_ch(msg, SSR_A_DIC))
        dic[msg.addr[4:3]] <= msg.data[3:0];
    end
  end

  // Low nibble of the return word
  always_comb
  begin
    nib = SSR_NIB_RST;
    unique case (rd_sel[2:0])
      SSR_A_STAT: nib = FAULT_I[rd_sel[4:3]];
      SSR_A_SOCH: nib = soch[rd_sel[4:3]];
      SSR_A_CDTOL: nib = cdtol[rd_sel[4:3]];
      SSR_A_DIC: nib = dic[rd_sel[4:3]];
      default:
      begin
        unique case (rd_sel)
          SSR_A_SERIAL_OUTPUT_COMMANDS: nib = on_cmd;
          SSR_A_SENSE_ENABLE_BITS: nib = sense_en_n;
          SSR_A_UOV: nib = uov;
          SSR_A_WD: nib = {1'b0, WD_EXPIRED_I, wdcfg[1:0]};
          SSR_A_PIN0: nib = {fsafe_s, WD_ACTIVE_I, wake_s};
          SSR_A_PIN1: nib = din_s;
          SSR_A_PIN2: nib = {wdcfg[3:2], 2'b00};
          default: nib = SSR_NIB_RST;
        endcase
      end
    endcase
  end

  always_comb
  begin
    for (int c = 0; c < SSR_CH_N; c++)
      st[c] = (|FAULT_I[c]) || flt_latch[c];
    word.wd = wd_echo;
    word.uv = LOW_SUPPLY_I;
    word.ov = HIGH_SUPPLY_I;
    word.sel = sel_echo;
    word.st = st;
    word.nib = nib;
  end

  // Snapshot frozen while the frame runs, so the shifter sees a stable word
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      snap <= SSR_WORD_RST;
    else if (CE_I && cs_s)
      snap <= seen ? word : SSR_WORD_RST;
  end

  // Latched faults need a switch-off; a new fault beats the clear
  always_comb
  begin
    for (int c = 0; c < SSR_CH_N; c++)
    begin
      latch_set[c] = FAULT_I[c].ot || FAULT_I[c].och || FAULT_I[c].ocl;
      off_cmd[c] = (accept && hit(msg, SSR_A_SERIAL_OUTPUT_COMMANDS) && !msg.data[c]) || (din_d[c] && !din_s[c]);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      flt_latch <= '0;
      din_d <= '0;
      FS_N_O <= 1'b1;
    end
    else if (CE_I)
    begin
      din_d <= din_s;
      flt_latch <= latch_set | (flt_latch & ~off_cmd);
      FS_N_O <= !((|flt_latch) || (|FAULT_I) || LOW_SUPPLY_I || HIGH_SUPPLY_I);
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  wd_echo_a: assert property (accept |=> wd_echo == $past(rx_word[15])) else $error("watchdog echo wrong");
  low_supply_a: assert property (CE_I && cs_s && seen |=> snap.uv == $past(LOW_SUPPLY_I)) else $error("uv bit wrong");
  high_supply_a: assert property (CE_I && cs_s && seen |=> snap.ov == $past(HIGH_SUPPLY_I)) else $error("ov bit wrong");
  sel_echo_a: assert property (accept |=> snap.sel == $past(sel_echo) ##1 sel_echo == $past(rx_word[4:0], 2)) else $error("selector echo wrong");
  summary_ch0_a: assert property (CE_I && cs_s && seen |=> snap.st[0] == $past(flt_latch[0] || (|FAULT_I[0]))) else $error("summary bit wrong");
  sel_load_a: assert property (accept && rx_word[10:8] == SSR_A_STAT |=> rd_sel == $past(rx_word[4:0])) else $error("selector not loaded");
  sel_hold_a: assert property (!accept |=> $stable(rd_sel)) else $error("selector moved");
  live_fault_a: assert property (CE_I && cs_s && seen && rd_sel[2:0] == SSR_A_STAT |=> snap.nib == $past(FAULT_I[rd_sel[4:3]])) else $error("fault nibble wrong");
  wd_nibble_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_WD |=> !snap.nib[3] && snap.nib[2] == $past(WD_EXPIRED_I)) else $error("watchdog nibble wrong");
  bad_frame_a: assert property (frame_end && !accept |=> $stable(on_cmd) && $stable(uov) && $stable(seen)) else $error("invalid frame changed state");
  reset_word_a: assert property (!seen && CE_I |=> snap == SSR_WORD_RST) else $error("word not zero before first message");
  frame_freeze_a: assert property (!cs_s ##1 !cs_s |-> $stable(snap)) else $error("snapshot moved in frame");
  fault_pin_a: assert property (CE_I && (|flt_latch) |=> !FS_N_O) else $error("fault pin not asserted");

  // Nibble sources, checked one code at a time against the stored fields, the pin inputs or zero
  oncmd_nib_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_SERIAL_OUTPUT_COMMANDS |=> snap.nib == $past(on_cmd)) else $error("on command nibble wrong");
  sense_nib_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_SENSE_ENABLE_BITS |=> snap.nib == $past(sense_en_n)) else $error("sense nibble wrong");
  soch_nib_a: assert property (CE_I && cs_s && seen && rd_sel[2:0] == SSR_A_SOCH |=> snap.nib == $past(soch[rd_sel[4:3]])) else $error("level nibble wrong");
  cdtol_nib_a: assert property (CE_I && cs_s && seen && rd_sel[2:0] == SSR_A_CDTOL |=> snap.nib == $past(cdtol[rd_sel[4:3]])) else $error("blanking nibble wrong");
  dic_nib_a: assert property (CE_I && cs_s && seen && rd_sel[2:0] == SSR_A_DIC |=> snap.nib == $past(dic[rd_sel[4:3]])) else $error("direct cfg nibble wrong");
  uov_nib_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_UOV |=> snap.nib == $past(uov)) else $error("supply cfg nibble wrong");
  pin0_nib_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_PIN0 |=> snap.nib == $past({fsafe_s, WD_ACTIVE_I, wake_s})) else $error("failsafe nibble wrong");
  pin1_nib_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_PIN1 |=> snap.nib == $past(din_s)) else $error("pin level nibble wrong");
  pin2_nib_a: assert property (CE_I && cs_s && seen && rd_sel == SSR_A_PIN2 |=> snap.nib[3:2] == $past(wdcfg[3:2])) else $error("thermal latch nibble wrong");
  spare_nib_a: assert property (CE_I && cs_s && seen && rd_sel[2:0] == 3'h7 && rd_sel != SSR_A_PIN2 |=> snap.nib == SSR_NIB_RST) else $error("unlisted code not zero");
  // A fresh fault in the same cycle keeps the latch, so the clear is checked alone
  latch_clear_a: assert property (accept && hit(msg, SSR_A_SERIAL_OUTPUT_COMMANDS) && !msg.data[0] && !latch_set[0] |=> !flt_latch[0]) else $error("latch not cleared");
  cfg_channel_a: assert property (accept && hit_ch(msg, SSR_A_SOCH) |=> soch[$past(msg.addr[4:3])] == $past(msg.data[3:0])) else $error("channel write misplaced");

  accept_c: cover property (accept);
  stat_write_c: cover property (accept && rx_word[10:8] == SSR_A_STAT);
  bad_frame_c: cover property (frame_end && !accept);
  fault_clear_c: cover property (!FS_N_O ##1 FS_N_O);
  wd_read_c: cover property (CE_I && cs_s && seen && rd_sel == SSR_A_WD);

endmodule

// ### dv/ssr_host.sv
// Host model for the serial link: frames chip select, clock and data in
// Assumes the device drives SO on the clock rise; clock period 30 ns
module ssr_host
(
  input wire logic so_i,
  input wire logic so_oe_n_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // Released SO comes back unknown, so a bit sent undriven never matches
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      // Data moves on the rise, away from the fall at which the device samples
      #15 sclk_o = 1'b1;
      si_o = tx[i];
      #15 sclk_o = 1'b0;
      rx = {rx[30:0], so_oe_n_i ? 1'bx : so_i};
    end
    #10 cs_n_o = 1'b1;
    // Idle data line shows the inverse, never the last bit
    si_o = ~si_o;
    #80;
  endtask
endmodule

// ### dv/tb_ssr_top.sv
// Self-checking bench for the serial status readback block
// Assumes the host model ssr_host; system clock 200 MHz
module tb_ssr_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic rst_n;
  logic sclk;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic fs_n;
  ssr_pkg::ssr_fault_t [3:0] fault;
  logic low_sup;
  logic high_sup;
  logic wd_exp;
  logic wd_act;
  logic [1:0] failsafe;
  logic wake;
  logic [3:0] direct;
  int num_errors = 0;
  int num_checks = 0;

  // Entries: write address, write data, selector, expected nibble
  localparam logic [18:0] TBL [10] = '{
    {5'h1a, 5'h05, 5'h1a, 4'h5}, {5'h0b, 5'h0c, 5'h0b, 4'hc},
    {5'h14, 5'h06, 5'h14, 4'h6}, {5'h09, 5'h03, 5'h09, 4'h3},
    {5'h05, 5'h0e, 5'h05, 4'he}, {5'h0d, 5'h0f, 5'h0d, 4'h7},
    {5'h06, 5'h00, 5'h0f, 4'hc}, {5'h06, 5'h00, 5'h06, 4'ha},
    {5'h06, 5'h00, 5'h0e, 4'h5}, {5'h06, 5'h00, 5'h07, 4'h0}};

  ssr_top u_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .SCLK_I(sclk), .CS_N_I(cs_n),
    .SI_I(si), .FAULT_I(fault), .LOW_SUPPLY_I(low_sup), .HIGH_SUPPLY_I(high_sup),
    .WD_EXPIRED_I(wd_exp), .WD_ACTIVE_I(wd_act), .FAILSAFE_OUT_I(failsafe),
    .WAKE_I(wake), .DIRECT_IN_I(direct), .SO_O(so), .SO_OE_N_O(so_oe_n),
    .FS_N_O(fs_n)
  );

  ssr_host u_host (
    .so_i(so), .so_oe_n_i(so_oe_n), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [15:0] msg(input logic wd, input logic [4:0] a,
                                      input logic [4:0] d);
    return {wd, 2'b00, a, 3'b000, d};
  endfunction

  task automatic xf(input logic [15:0] m, output logic [15:0] r);
    logic [31:0] w;
    u_host.xfer({16'h0000, m}, 16, w);
    r = w[15:0];
  endtask

  task automatic t_reset_word();
    logic [15:0] r;
    chk("oe_n idle", 16'h0001, {15'h0000, so_oe_n});
    xf(msg(1'b1, 5'h00, 5'h01), r);
    chk("first word", 16'h0000, r);
  endtask

  task automatic t_oncmd_echo();
    logic [15:0] r;
    xf(msg(1'b0, 5'h01, 5'h0a), r);
    chk("word", 16'h8100, r);
    xf(msg(1'b1, 5'h06, 5'h00), r);
    chk("word", 16'h0a0a, r);
  endtask

  task automatic t_fault_pin();
    logic [15:0] r;
    @(negedge clk);
    fault[2] = 4'b1001;
    low_sup = 1'b1;
    high_sup = 1'b1;
    xf(msg(1'b0, 5'h10, 5'h10), r);
    chk("word", 16'he04a, r);
    xf(msg(1'b1, 5'h06, 5'h00), r);
    chk("word", 16'h7049, r);
    chk("fs_n", 16'h0000, {15'h0000, fs_n});
    @(negedge clk);
    fault = '0;
    low_sup = 1'b0;
    high_sup = 1'b0;
    repeat (6) @(negedge clk);
    chk("fs_n held", 16'h0000, {15'h0000, fs_n});
    xf(msg(1'b0, 5'h01, 5'h00), r);
    repeat (6) @(negedge clk);
    chk("fs_n freed", 16'h0001, {15'h0000, fs_n});
  endtask

  task automatic t_readback_table();
    logic [15:0] r;
    logic [18:0] e;
    @(negedge clk);
    wd_exp = 1'b1;
    wd_act = 1'b1;
    failsafe = 2'b10;
    direct = 4'h5;
    for (int i = 0; i < 10; i++)
    begin
      e = TBL[i];
      xf(msg(1'b0, e[18:14], e[13:9]), r);
      xf(msg(1'b0, {e[8:7], 3'b000}, e[8:4]), r);
      xf(msg(1'b0, 5'h06, 5'h00), r);
      chk("echo", {11'h000, e[8:4]}, {11'h000, r[12:8]});
      chk("nibble", {12'h000, e[3:0]}, {12'h000, r[3:0]});
    end
  endtask

  task automatic t_frame_rules();
    logic [15:0] r;
    logic [31:0] w;
    xf(msg(1'b0, 5'h08, 5'h0e), r);
    // Short frame must leave selector and echo alone
    u_host.xfer(32'h0000_00ff, 8, w);
    u_host.xfer({16'h1234, msg(1'b1, 5'h06, 5'h00)}, 32, w);
    chk("word", 16'h0e05, w[31:16]);
    chk("chain", 16'h1234, w[15:0]);
    chk("oe_n", 16'h0001, {15'h0000, so_oe_n});
  endtask

  initial
  begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    fault = '0;
    low_sup = 1'b0;
    high_sup = 1'b0;
    wd_exp = 1'b0;
    wd_act = 1'b0;
    failsafe = 2'b00;
    wake = 1'b0;
    direct = 4'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    // Offset the link from the system clock phase
    #7.3;
    t_reset_word();
    t_oncmd_echo();
    t_fault_pin();
    t_readback_table();
    t_frame_rules();
    report_and_stop();
  end
endmodule
